//--- design/stl_top.sv
// over-travel gating, torque clamp selection and power-up sequencing
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_top #(
   parameter int READY_DELAY_CYC = int'(`STL_READY_DELAY_S * `STL_CLK_HZ)
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic [7:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic I_CLOCKWISE_TRAVEL_STOP_IN,
   input wire logic I_COUNTERCLOCKWISE_TRAVEL_STOP_IN,
   input wire logic I_CW_EXTERNAL_CLAMP_SELECT_IN,
   input wire logic I_CCW_EXTERNAL_CLAMP_SELECT_IN,
   input wire logic I_PRESET_TORQUE_SELECT_LOW,
   input wire logic I_PRESET_TORQUE_SELECT_HIGH,
   input wire logic I_SERVO_ENABLE_IN,
   input wire logic I_MAIN_POWER_OK,
   input wire logic I_ALARM,
   input wire logic I_TRIAL_RUN,
   input wire logic signed [9:0] I_ANALOG_TORQUE,
   input wire logic signed [9:0] I_TORQUE_CMD,
   output logic signed [9:0] O_TORQUE_OUT,
   output logic O_CW_INHIBIT,
   output logic O_CCW_INHIBIT,
   output logic O_READY,
   output logic O_POWER_STAGE_EN
);

   localparam logic [25:0] RDY_LAST = 26'(READY_DELAY_CYC - 1);
   // settings
   stl_pkg::stl_ot_e overtravel_honour_setting_r;
   stl_pkg::stl_src_e torque_clamp_source_select_r;
   stl_pkg::stl_trq_t internal_ccw_torque_clamp_r;
   stl_pkg::stl_trq_t internal_cw_torque_clamp_r;
   stl_pkg::stl_trq_t external_ccw_torque_clamp_r;
   stl_pkg::stl_trq_t external_cw_torque_clamp_r;
   stl_pkg::stl_trq_t trial_run_torque_clamp_r;
   stl_pkg::stl_trq_t preset_torque_r [4];

   // filtered pins and derived state
   logic [`STL_PIN_COUNT-1:0] pins_async;
   logic [`STL_PIN_COUNT-1:0] pins_f;
   stl_pkg::stl_pwr_e pwr_r;
   stl_pkg::stl_pwr_e pwr_nxt;
   logic [25:0] rdy_cnt_r;
   logic ack_r;
   logic req;
   logic wr_ok;
   logic [31:0] rd_nxt;
   stl_pkg::stl_trq_t wr_val;
   stl_pkg::stl_wide_t ccw_nxt;
   stl_pkg::stl_wide_t cw_nxt;
   stl_pkg::stl_wide_t ana_mag;
   stl_pkg::stl_wide_t pre_sel;
   stl_pkg::stl_wide_t cmd_w;
   stl_pkg::stl_wide_t out_nxt;
   logic cw_inh_nxt;
   logic ccw_inh_nxt;
   stl_pkg::stl_trq_t ccw_lim_r;
   stl_pkg::stl_trq_t cw_lim_r;

   function automatic stl_pkg::stl_wide_t smin(stl_pkg::stl_wide_t a, stl_pkg::stl_wide_t b);
      return (a < b) ? a : b;
   endfunction : smin
   function automatic stl_pkg::stl_wide_t smax(stl_pkg::stl_wide_t a, stl_pkg::stl_wide_t b);
      return (a > b) ? a : b;
   endfunction : smax
   // saturate a written percentage into its legal range
   function automatic stl_pkg::stl_trq_t sat(stl_pkg::stl_trq_t v, stl_pkg::stl_trq_t lo,
                                             stl_pkg::stl_trq_t hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : sat

   // the eight switch, select, enable and power pins cross into the core clock together; alarm and trial run do not
   assign pins_async = {I_MAIN_POWER_OK, I_SERVO_ENABLE_IN, I_PRESET_TORQUE_SELECT_HIGH,
                        I_PRESET_TORQUE_SELECT_LOW, I_CCW_EXTERNAL_CLAMP_SELECT_IN,
                        I_CW_EXTERNAL_CLAMP_SELECT_IN, I_COUNTERCLOCKWISE_TRAVEL_STOP_IN,
                        I_CLOCKWISE_TRAVEL_STOP_IN};

   stl_sync #(.WIDTH(`STL_PIN_COUNT)) u_pin_sync (
      .i_clk(I_CORE_CLK),
      .i_reset_n(I_RESET_N),
      .i_async(pins_async),
      .o_level(pins_f)
   );

   // bus handshake: one wait state, then the access completes
   assign req = I_AVS_READ | I_AVS_WRITE;
   assign O_AVS_WAITREQUEST = req & ~ack_r;
   assign wr_ok = I_AVS_WRITE & ack_r & (&I_AVS_BYTEENABLE[1:0]);
   assign wr_val = I_AVS_WRITEDATA[9:0];

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // read mux; unmapped words read as zero
   always_comb begin
      rd_nxt = 32'h0;
      unique case (I_AVS_ADDRESS)
         `STL_OFS_CTRL: begin
            rd_nxt[`STL_CTRL_OT_LSB +: 2] = overtravel_honour_setting_r;
            rd_nxt[`STL_CTRL_SRC_LSB +: 2] = torque_clamp_source_select_r;
         end
         `STL_OFS_INT_CCW: rd_nxt[9:0] = internal_ccw_torque_clamp_r;
         `STL_OFS_INT_CW: rd_nxt[9:0] = internal_cw_torque_clamp_r;
         `STL_OFS_EXT_CCW: rd_nxt[9:0] = external_ccw_torque_clamp_r;
         `STL_OFS_EXT_CW: rd_nxt[9:0] = external_cw_torque_clamp_r;
         `STL_OFS_TRIAL: rd_nxt[9:0] = trial_run_torque_clamp_r;
         `STL_OFS_PRE1: rd_nxt[9:0] = preset_torque_r[0];
         `STL_OFS_PRE2: rd_nxt[9:0] = preset_torque_r[1];
         `STL_OFS_PRE3: rd_nxt[9:0] = preset_torque_r[2];
         `STL_OFS_PRE4: rd_nxt[9:0] = preset_torque_r[3];
         `STL_OFS_STATUS: begin
            rd_nxt[`STL_ST_READY] = O_READY;
            rd_nxt[`STL_ST_PWR] = O_POWER_STAGE_EN;
            rd_nxt[`STL_ST_CW_INH] = O_CW_INHIBIT;
            rd_nxt[`STL_ST_CCW_INH] = O_CCW_INHIBIT;
            rd_nxt[`STL_ST_MAIN] = pins_f[`STL_PIN_MAIN];
            rd_nxt[`STL_ST_SON] = pins_f[`STL_PIN_SON];
         end
         `STL_OFS_LIMITS: begin
            rd_nxt[9:0] = ccw_lim_r;
            rd_nxt[`STL_LIM_CW_LSB +: 10] = cw_lim_r;
         end
         default: rd_nxt = 32'h0;
      endcase
   end

   // read data is captured in the wait cycle and stands at the completing edge
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_AVS_READDATA <= 32'h0;
      end else if (I_AVS_READ && !ack_r) begin
         O_AVS_READDATA <= rd_nxt;
      end
   end

   // control word; source values above two saturate
   // setting resets
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         overtravel_honour_setting_r <= stl_pkg::stl_ot_e'(`STL_RST_OT);
         torque_clamp_source_select_r <= stl_pkg::stl_src_e'(`STL_RST_SRC);
      end else if (wr_ok && I_AVS_ADDRESS == `STL_OFS_CTRL) begin
         overtravel_honour_setting_r <= stl_pkg::stl_ot_e'(I_AVS_WRITEDATA[`STL_CTRL_OT_LSB +: 2]);
         torque_clamp_source_select_r <=
            (I_AVS_WRITEDATA[`STL_CTRL_SRC_LSB +: 2] > `STL_SRC_MAX) ?
            stl_pkg::stl_src_e'(`STL_SRC_MAX) :
            stl_pkg::stl_src_e'(I_AVS_WRITEDATA[`STL_CTRL_SRC_LSB +: 2]);
      end
   end

   // clamp settings, saturated into their ranges on write
   // ranges and resets
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         internal_ccw_torque_clamp_r <= `STL_RST_INT_CCW;
         internal_cw_torque_clamp_r <= `STL_RST_INT_CW;
         external_ccw_torque_clamp_r <= `STL_RST_EXT_CCW;
         external_cw_torque_clamp_r <= `STL_RST_EXT_CW;
         trial_run_torque_clamp_r <= `STL_RST_TRIAL;
      end else if (wr_ok) begin
         unique case (I_AVS_ADDRESS)
            `STL_OFS_INT_CCW: internal_ccw_torque_clamp_r <= sat(wr_val, 10'h000, `STL_TRQ_MAX);
            `STL_OFS_INT_CW: internal_cw_torque_clamp_r <= sat(wr_val, `STL_TRQ_MIN, 10'h000);
            `STL_OFS_EXT_CCW: external_ccw_torque_clamp_r <= sat(wr_val, 10'h000, `STL_TRQ_MAX);
            `STL_OFS_EXT_CW: external_cw_torque_clamp_r <= sat(wr_val, `STL_TRQ_MIN, 10'h000);
            `STL_OFS_TRIAL: trial_run_torque_clamp_r <= sat(wr_val, 10'h000, `STL_TRQ_MAX);
            default: begin
            end
         endcase
      end
   end

   // four preset magnitudes, each one aligned word
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         for (int i = 0; i < 4; i++) begin
            preset_torque_r[i] <= `STL_RST_PRESET;
         end
      end else if (wr_ok && I_AVS_ADDRESS >= `STL_OFS_PRE1 && I_AVS_ADDRESS <= `STL_OFS_PRE4) begin
         preset_torque_r[2'(I_AVS_ADDRESS[7:2] - 6'(`STL_OFS_PRE1 >> 2))] <=
            sat(wr_val, 10'h000, `STL_TRQ_MAX);
      end
   end

   // power sequencing: wait, ready, running
   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         stl_pkg::STL_PWR_OFF: if (pins_f[`STL_PIN_MAIN]) pwr_nxt = stl_pkg::STL_PWR_WAIT;
         stl_pkg::STL_PWR_WAIT: begin
            if (!pins_f[`STL_PIN_MAIN]) pwr_nxt = stl_pkg::STL_PWR_OFF;
            else if (rdy_cnt_r == RDY_LAST) pwr_nxt = stl_pkg::STL_PWR_RDY;
         end
         stl_pkg::STL_PWR_RDY: begin
            if (!pins_f[`STL_PIN_MAIN]) pwr_nxt = stl_pkg::STL_PWR_OFF;
            else if (pins_f[`STL_PIN_SON] && !I_ALARM) pwr_nxt = stl_pkg::STL_PWR_RUN;
         end
         stl_pkg::STL_PWR_RUN: begin
            if (!pins_f[`STL_PIN_MAIN]) pwr_nxt = stl_pkg::STL_PWR_OFF;
            else if (!pins_f[`STL_PIN_SON] || I_ALARM) pwr_nxt = stl_pkg::STL_PWR_RDY;
         end
         default: pwr_nxt = stl_pkg::STL_PWR_OFF;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pwr_r <= stl_pkg::STL_PWR_OFF;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // delay counter, restarted on every power loss
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rdy_cnt_r <= 26'h0000000;
      end else if (pwr_r == stl_pkg::STL_PWR_WAIT && pins_f[`STL_PIN_MAIN]) begin
         rdy_cnt_r <= rdy_cnt_r + 26'h0000001;
      end else begin
         rdy_cnt_r <= 26'h0000000;
      end
   end

   // ready only in ready or running states
   assign O_READY = (pwr_r == stl_pkg::STL_PWR_RDY) || (pwr_r == stl_pkg::STL_PWR_RUN);
   assign O_POWER_STAGE_EN = (pwr_r == stl_pkg::STL_PWR_RUN);
   // honoured stop input open means over-travel
   assign cw_inh_nxt = !pins_f[`STL_PIN_CW_STOP] &&
      (overtravel_honour_setting_r == stl_pkg::STL_OT_BOTH ||
       overtravel_honour_setting_r == stl_pkg::STL_OT_CW_ONLY);
   assign ccw_inh_nxt = !pins_f[`STL_PIN_CCW_STOP] &&
      (overtravel_honour_setting_r == stl_pkg::STL_OT_BOTH ||
       overtravel_honour_setting_r == stl_pkg::STL_OT_CCW_ONLY);

   assign ana_mag = (I_ANALOG_TORQUE < 0) ? -stl_pkg::stl_wide_t'(I_ANALOG_TORQUE) :
                    stl_pkg::stl_wide_t'(I_ANALOG_TORQUE);
   assign pre_sel = stl_pkg::stl_wide_t'(preset_torque_r[{pins_f[`STL_PIN_PRE_HI],
                                                          pins_f[`STL_PIN_PRE_LO]}]);
   assign cmd_w = stl_pkg::stl_wide_t'(I_TORQUE_CMD);

   // bound composition; ccw positive, cw negative
   always_comb begin
      // basic selection by external select inputs
      ccw_nxt = pins_f[`STL_PIN_CCW_SEL] ? stl_pkg::stl_wide_t'(external_ccw_torque_clamp_r) :
                stl_pkg::stl_wide_t'(internal_ccw_torque_clamp_r);
      cw_nxt = pins_f[`STL_PIN_CW_SEL] ? stl_pkg::stl_wide_t'(external_cw_torque_clamp_r) :
               stl_pkg::stl_wide_t'(internal_cw_torque_clamp_r);
      ccw_nxt = smin(ccw_nxt, stl_pkg::stl_wide_t'(internal_ccw_torque_clamp_r));
      cw_nxt = smax(cw_nxt, stl_pkg::stl_wide_t'(internal_cw_torque_clamp_r));
      if (torque_clamp_source_select_r == stl_pkg::STL_SRC_ANALOG) begin
         ccw_nxt = smin(ccw_nxt, ana_mag);
         cw_nxt = smax(cw_nxt, -ana_mag);
      end else if (torque_clamp_source_select_r == stl_pkg::STL_SRC_PRESET) begin
         ccw_nxt = smin(ccw_nxt, pre_sel);
         cw_nxt = smax(cw_nxt, -pre_sel);
      end
      // trial running adds its own symmetric clamp
      if (I_TRIAL_RUN) begin
         ccw_nxt = smin(ccw_nxt, stl_pkg::stl_wide_t'(trial_run_torque_clamp_r));
         cw_nxt = smax(cw_nxt, -stl_pkg::stl_wide_t'(trial_run_torque_clamp_r));
      end
      if (ccw_inh_nxt) ccw_nxt = 11'sh000;
      if (cw_inh_nxt) cw_nxt = 11'sh000;
      out_nxt = (pwr_nxt == stl_pkg::STL_PWR_RUN) ?
                smax(smin(cmd_w, ccw_nxt), cw_nxt) : 11'sh000;
   end

   // bound registered every cycle; output zero while stage off
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ccw_lim_r <= 10'h000;
         cw_lim_r <= 10'h000;
         O_CW_INHIBIT <= 1'b0;
         O_CCW_INHIBIT <= 1'b0;
         O_TORQUE_OUT <= 10'h000;
      end else begin
         ccw_lim_r <= ccw_nxt[9:0];
         cw_lim_r <= cw_nxt[9:0];
         O_CW_INHIBIT <= cw_inh_nxt;
         O_CCW_INHIBIT <= ccw_inh_nxt;
         O_TORQUE_OUT <= out_nxt[9:0];
      end
   end

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   AST_OT_NONE: assert property (overtravel_honour_setting_r == stl_pkg::STL_OT_NONE
      |=> !O_CW_INHIBIT && !O_CCW_INHIBIT) else $error("limit inhibits while ignored");
   AST_CW_STOP: assert property (O_CW_INHIBIT |-> O_TORQUE_OUT >= 0)
      else $error("cw torque while cw inhibited");
   AST_CCW_STOP: assert property (O_CCW_INHIBIT |-> O_TORQUE_OUT <= 0)
      else $error("ccw torque while ccw inhibited");
   AST_REVERSE: assert property (O_CW_INHIBIT && !O_CCW_INHIBIT && O_POWER_STAGE_EN &&
      $past(I_TORQUE_CMD) > 0 |-> O_TORQUE_OUT == (($past(I_TORQUE_CMD) < ccw_lim_r) ?
      $past(I_TORQUE_CMD) : ccw_lim_r)) else $error("reverse path lost");
   AST_BOUND: assert property (O_TORQUE_OUT <= ccw_lim_r && O_TORQUE_OUT >= cw_lim_r)
      else $error("torque outside bound");
   AST_INT_ALWAYS: assert property (ccw_lim_r <= $past(internal_ccw_torque_clamp_r)
      && cw_lim_r >= $past(internal_cw_torque_clamp_r)) else $error("internal limit ignored");
   AST_ANALOG: assert property (torque_clamp_source_select_r == stl_pkg::STL_SRC_ANALOG
      |=> ccw_lim_r <= $past(ana_mag) && cw_lim_r >= -$past(ana_mag))
      else $error("analog clamp missing");
   AST_PRESET: assert property (torque_clamp_source_select_r == stl_pkg::STL_SRC_PRESET
      |=> ccw_lim_r <= $past(pre_sel)) else $error("preset clamp missing");
   AST_NO_MAIN: assert property (!pins_f[`STL_PIN_MAIN] |=> !O_READY)
      else $error("ready without main power");
   AST_RDY_DELAY: assert property ($rose(O_READY) |-> $past(rdy_cnt_r) == RDY_LAST)
      else $error("ready before delay");
   AST_SON: assert property (O_READY && pins_f[`STL_PIN_SON] && !I_ALARM &&
      pins_f[`STL_PIN_MAIN] |=> O_POWER_STAGE_EN) else $error("stage not enabled");
   AST_OFF: assert property (I_ALARM || !pins_f[`STL_PIN_SON] |=> !O_POWER_STAGE_EN)
      else $error("stage on with alarm or enable off");
   COV_READY: cover property ($rose(O_READY));
   COV_RUN: cover property ($rose(O_POWER_STAGE_EN));
   COV_OT: cover property (O_CW_INHIBIT && O_TORQUE_OUT > 0);
   COV_PRESET: cover property (torque_clamp_source_select_r == stl_pkg::STL_SRC_PRESET
      && ccw_lim_r < internal_ccw_torque_clamp_r);

endmodule : stl_top
`default_nettype wire

//--- design/stl_cfg.svh
// offsets, field positions, reset values and timing of the travel/torque limit block
`ifndef STL_CFG_SVH
`define STL_CFG_SVH

// register byte offsets
`define STL_OFS_CTRL 8'h00
`define STL_OFS_INT_CCW 8'h04
`define STL_OFS_INT_CW 8'h08
`define STL_OFS_EXT_CCW 8'h0C
`define STL_OFS_EXT_CW 8'h10
`define STL_OFS_TRIAL 8'h14
`define STL_OFS_PRE1 8'h18
`define STL_OFS_PRE2 8'h1C
`define STL_OFS_PRE3 8'h20
`define STL_OFS_PRE4 8'h24
`define STL_OFS_STATUS 8'h28
`define STL_OFS_LIMITS 8'h2C

// field positions
`define STL_CTRL_OT_LSB 0
`define STL_CTRL_SRC_LSB 2
`define STL_ST_READY 0
`define STL_ST_PWR 1
`define STL_ST_CW_INH 2
`define STL_ST_CCW_INH 3
`define STL_ST_MAIN 4
`define STL_ST_SON 5
`define STL_LIM_CW_LSB 16

// pin vector positions
`define STL_PIN_CW_STOP 0
`define STL_PIN_CCW_STOP 1
`define STL_PIN_CW_SEL 2
`define STL_PIN_CCW_SEL 3
`define STL_PIN_PRE_LO 4
`define STL_PIN_PRE_HI 5
`define STL_PIN_SON 6
`define STL_PIN_MAIN 7
`define STL_PIN_COUNT 8

// reset values (percent, two's complement)
`define STL_RST_OT 2'h3
`define STL_RST_SRC 2'h0
`define STL_RST_INT_CCW 10'h12C
`define STL_RST_INT_CW 10'h2D4
`define STL_RST_EXT_CCW 10'h064
`define STL_RST_EXT_CW 10'h39C
`define STL_RST_TRIAL 10'h064
`define STL_RST_PRESET 10'h064

// setting ranges
`define STL_TRQ_MAX 10'h12C
`define STL_TRQ_MIN 10'h2D4
`define STL_SRC_MAX 2'h2

// timing
`define STL_CLK_HZ 25000000
`define STL_READY_DELAY_S 1.5

`endif

//--- design/stl_pkg.sv
// types of the travel/torque limit block
package stl_pkg;

   typedef logic signed [9:0] stl_trq_t;
   typedef logic signed [10:0] stl_wide_t;

   typedef enum logic [1:0] {
      STL_OT_BOTH = 2'h0,
      STL_OT_CW_ONLY = 2'h1,
      STL_OT_CCW_ONLY = 2'h2,
      STL_OT_NONE = 2'h3
   } stl_ot_e;

   typedef enum logic [1:0] {
      STL_SRC_BASIC = 2'h0,
      STL_SRC_ANALOG = 2'h1,
      STL_SRC_PRESET = 2'h2
   } stl_src_e;

   typedef enum logic [3:0] {
      STL_PWR_OFF = 4'h1,
      STL_PWR_WAIT = 4'h2,
      STL_PWR_RDY = 4'h4,
      STL_PWR_RUN = 4'h8
   } stl_pwr_e;

endpackage : stl_pkg

//--- design/stl_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module stl_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // shift chain; only s2 reads s1
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= i_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes only where the last two stages agree
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_level <= '0;
      end else begin
         o_level <= (s2_r & s3_r) | (o_level & (s2_r ^ s3_r));
      end
   end

endmodule : stl_sync
`default_nettype wire

//--- tb/stl_far_side.sv
// far-side model: limit switches and host digital outputs
`timescale 1ns/1ps
`default_nettype none

module stl_far_side (
   input wire logic i_cw_over,
   input wire logic i_ccw_over,
   input wire logic [5:0] i_di,
   output logic o_cw_stop,
   output logic o_ccw_stop,
   output logic [5:0] o_di
);
   // normally closed switches
   // an open contact reads low, so a cut wire also halts travel
   assign o_cw_stop = ~i_cw_over;
   assign o_ccw_stop = ~i_ccw_over;
   // host levels pass straight through
   assign o_di = i_di;
endmodule : stl_far_side
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the travel and torque limit block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic cw_over = 1'b0;
   logic ccw_over = 1'b0;
   logic [5:0] di = 6'h00;
   logic [5:0] pin;
   logic cw_stop;
   logic ccw_stop;
   logic alarm = 1'b0;
   logic trial = 1'b0;
   logic signed [9:0] ana = 10'h000;
   logic signed [9:0] cmd = 10'h000;
   logic signed [9:0] tq;
   logic cw_inh;
   logic ccw_inh;
   logic rdy;
   logic pwr_en;
   int miscompares = 0;
   int total_checks = 0;
   int r [0:9];

   // 25 MHz core clock
   always #20 clk = ~clk;

   // ready delay shortened so power-up fits the run
   stl_top #(.READY_DELAY_CYC(20)) DUT (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
      .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
      .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
      .I_CLOCKWISE_TRAVEL_STOP_IN(cw_stop), .I_COUNTERCLOCKWISE_TRAVEL_STOP_IN(ccw_stop),
      .I_CW_EXTERNAL_CLAMP_SELECT_IN(pin[0]), .I_CCW_EXTERNAL_CLAMP_SELECT_IN(pin[1]),
      .I_PRESET_TORQUE_SELECT_LOW(pin[2]), .I_PRESET_TORQUE_SELECT_HIGH(pin[3]),
      .I_SERVO_ENABLE_IN(pin[4]), .I_MAIN_POWER_OK(pin[5]), .I_ALARM(alarm),
      .I_TRIAL_RUN(trial), .I_ANALOG_TORQUE(ana), .I_TORQUE_CMD(cmd), .O_TORQUE_OUT(tq),
      .O_CW_INHIBIT(cw_inh), .O_CCW_INHIBIT(ccw_inh), .O_READY(rdy),
      .O_POWER_STAGE_EN(pwr_en));

   stl_far_side far (.i_cw_over(cw_over), .i_ccw_over(ccw_over), .i_di(di),
      .o_cw_stop(cw_stop), .o_ccw_stop(ccw_stop), .o_di(pin));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one avalon access; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      wr <= w;
      rd <= ~w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      while (wreq !== 1'b0) begin
         @(posedge clk);
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   // expected clamped torque from settings and pin levels
   function automatic int lim(input int ot, input int src, input int cwo, input int ccwo,
         input int cs, input int ccs, input int pi, input int tr, input int an,
         input int c);
      int hi;
      int lo;
      int m;
      hi = ccs ? r[3] : r[1];
      lo = cs ? r[4] : r[2];
      m = (src == 1) ? ((an < 0) ? -an : an) : (src == 2) ? r[6 + pi] : 300;
      if (tr != 0 && r[5] < m) m = r[5];
      if (r[1] < hi) hi = r[1];
      if (m < hi) hi = m;
      if (r[2] > lo) lo = r[2];
      if (-m > lo) lo = -m;
      if (cwo != 0 && ot < 2) lo = 0;
      if (ccwo != 0 && (ot == 0 || ot == 2)) hi = 0;
      return (c > hi) ? hi : ((c < lo) ? lo : c);
   endfunction : lim

   initial begin
      logic [31:0] q;
      int rv [0:5];
      int ot;
      int e;
      rv = '{3, 300, -300, 100, -100, 100};
      void'($urandom(2025));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, 8'(k * 4), 32'h0, q);
         chk("reset value", {22'h0, 10'(rv[k])}, q);
      end
      bus(1'b0, 8'h30, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      bus(1'b0, 8'h2C, 32'h0, q);
      chk("limits at reset", 32'h02D4012C, q);
      bus(1'b1, 8'h00, 32'h0000000F, q);
      bus(1'b0, 8'h00, 32'h0, q);
      chk("source saturates", 32'h0000000B, q);
      bus(1'b1, 8'h04, 32'h00000190, q);
      bus(1'b0, 8'h04, 32'h0, q);
      chk("ccw limit saturates", 32'h0000012C, q);
      $display("register test done");
      // servo enable raised early, main power still off
      di <= 6'h10;
      repeat (30) @(posedge clk);
      chk("ready without main", 32'h0, {31'h0, rdy});
      chk("stage before ready", 32'h0, {31'h0, pwr_en});
      di <= 6'h30;
      repeat (12) @(posedge clk);
      chk("ready too early", 32'h0, {31'h0, rdy});
      for (int k = 0; k < 40 && rdy !== 1'b1; k++) @(posedge clk);
      chk("ready rises", 32'h1, {31'h0, rdy});
      chk("stage waits ready", 32'h0, {31'h0, pwr_en});
      repeat (3) @(posedge clk);
      chk("stage on", 32'h1, {31'h0, pwr_en});
      bus(1'b0, 8'h28, 32'h0, q);
      chk("status running", 32'h00000033, q);
      $display("power test done");
      for (int it = 0; it < 40; it++) begin
         ot = (it < 4) ? it : int'($urandom_range(3, 0));
         bus(1'b1, 8'h00, 32'((it % 3) * 4 + ot), q);
         for (int k = 1; k < 10; k++) begin
            e = int'($urandom_range(300, 0));
            r[k] = (k == 2 || k == 4) ? -e : e;
            bus(1'b1, 8'(k * 4), {22'h0, 10'(r[k])}, q);
         end
         // first rounds hold both travel stops open
         cw_over <= (it < 4) ? 1'b1 : 1'($urandom_range(1, 0));
         ccw_over <= (it < 4) ? 1'b1 : 1'($urandom_range(1, 0));
         di <= {2'b11, 4'($urandom_range(15, 0))};
         trial <= 1'($urandom_range(1, 0));
         ana <= 10'(int'($urandom_range(600, 0)) - 300);
         cmd <= 10'(int'($urandom_range(800, 0)) - 400);
         // sync filter plus output register settle
         repeat (8) @(posedge clk);
         e = lim(ot, it % 3, cw_over, ccw_over, di[0], di[1], int'(di[3:2]), trial, ana, cmd);
         chk("torque out", {22'h0, 10'(e)}, {22'h0, tq});
         chk("cw inhibit", {31'h0, ot < 2 && cw_over}, {31'h0, cw_inh});
         chk("ccw inhibit", {31'h0, (ot == 0 || ot == 2) && ccw_over}, {31'h0, ccw_inh});
      end
      $display("clamp test done");
      alarm <= 1'b1;
      repeat (3) @(posedge clk);
      chk("stage off on alarm", 32'h0, {31'h0, pwr_en});
      chk("torque off on alarm", 32'h0, {22'h0, tq});
      alarm <= 1'b0;
      repeat (3) @(posedge clk);
      chk("stage back on", 32'h1, {31'h0, pwr_en});
      di <= 6'h20;
      repeat (8) @(posedge clk);
      chk("stage off without enable", 32'h0, {31'h0, pwr_en});
      $display("shutdown test done");
      print_verdict();
   end

   // cuts a hang well past the expected run of under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("[ERR] watchdog expected finish seen timeout");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
